/* src/qoc_top.sv */
// Control and status logic for a four-channel digital output unit.
// Function
// - Each channel individually enabled; disabled never drives.
// - On stop: off, hold, or substitute one.
// - Parameters arrive as record 128, three bytes.
// - Quality option adds byte, bits 0-3 per channel.
// - Quality bit 1 healthy, 0 disabled or error.
// - Any error clears all four quality bits.
// - Input byte present only with quality option.
// - Fault lamp: off, flash unset, on, flash fault_lamp.
// - Channel lamp lit when enabled and its output is one.
// - Supply lamp follows load supply presence.
// - Load-supply status bit always reads one.
// - Alarm on channel unavailable or parameter error.
// - Parameter error reports code 10 hex.
// - Firmware update reports 1F, ignores process values.
// - One alarm per event; lamp flashes meanwhile.
`timescale 1ns/100ps
module qoc_top
  import qoc_pkg::*;
#(
  parameter int unsigned FLASH_CYC = FLASH_HALF_CYC
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        rec_wr_valid,
  input  wire logic [15:0] rec_index,
  input  wire logic [7:0]  rec_len,
  input  wire logic [23:0] rec_data,
  output      logic        rec_wr_done,
  output      logic        rec_wr_err,
  input  wire logic        out_wr_valid,
  input  wire logic [7:0]  output_image,
  input  wire logic        ctrl_stop_pin,
  input  wire logic        bp_supply_ok_pin,
  input  wire logic        load_supply_pin,
  input  wire logic        fw_update_run_pin,
  input  wire logic        fw_update_abort_pin,
  output      logic [3:0]  chan_out,
  output      logic [3:0]  chan_lamp,
  output      logic        fault_lamp_green,
  output      logic        fault_lamp_red,
  output      logic        supply_lamp,
  output      logic [7:0]  load_status,
  output      logic        input_image_present,
  output      logic [7:0]  quality_info,
  output      logic        fault_lamp_alarm,
  output      logic [7:0]  fault_lamp_code,
  output      logic        fault_lamp_active
);
  localparam int unsigned CW = $clog2(FLASH_CYC + 1);
  localparam logic [CW-1:0] FLASH_LAST = CW'(FLASH_CYC - 1);

  logic [4:0]    pins_s;
  logic          stop_s;
  logic          bp_ok_s;
  logic          load_ok_s;
  logic          fw_run_s;
  logic          fw_abort_s;
  logic [3:0]    cfg_en_r;
  logic [7:0]    cfg_react_r;
  logic          cfg_qopt_r;
  logic          assigned_r;
  logic          param_err_r;
  logic          fw_abort_r;
  logic          fw_unavail;
  logic          fault_lamp_any;
  logic          perr_q_r;
  logic          fwu_q_r;
  logic          alarm_r;
  logic [7:0]    code_r;
  logic          done_r;
  logic          err_r;
  logic [7:0]    quality_r;
  logic          present_r;
  logic [CW-1:0] flash_cnt_r;
  logic          flash_r;
  logic          green_r;
  logic          red_r;
  logic          supply_r;
  qoc_lamp_t     lamp_mode;
  logic          rec_hit;
  logic          rec_ok;
  logic          proc_load;

  qoc_sync #(
    .W (5)
  ) u_sync (
    .mclk (mclk),
    .nrst (nrst),
    .d    ({ctrl_stop_pin, bp_supply_ok_pin, load_supply_pin,
            fw_update_run_pin, fw_update_abort_pin}),
    .q    (pins_s)
  );
  assign {stop_s, bp_ok_s, load_ok_s, fw_run_s, fw_abort_s} = pins_s;

  // A reaction code of three has no meaning, so such a record is refused whole.
  assign rec_hit = rec_wr_valid && (rec_index == PARAM_REC_IDX);
  assign rec_ok  = rec_hit && (rec_len == PARAM_REC_LEN)
                   && (rec_data[REACT_LSB+1:REACT_LSB] != 2'b11)
                   && (rec_data[REACT_LSB+3:REACT_LSB+2] != 2'b11)
                   && (rec_data[REACT_LSB+5:REACT_LSB+4] != 2'b11)
                   && (rec_data[REACT_LSB+7:REACT_LSB+6] != 2'b11);

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_en_r    <= EN_RST;
      cfg_react_r <= REACT_RST;
      cfg_qopt_r  <= QOPT_RST;
      assigned_r  <= 1'b0;
    end
    else if (rec_ok)
    begin
      cfg_en_r    <= rec_data[EN_LSB+3:EN_LSB];
      cfg_react_r <= rec_data[REACT_LSB+7:REACT_LSB];
      cfg_qopt_r  <= rec_data[QOPT_BIT];
      assigned_r  <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      param_err_r <= 1'b0;
      done_r      <= 1'b0;
      err_r       <= 1'b0;
    end
    else
    begin
      done_r <= rec_ok;
      err_r  <= rec_wr_valid && !rec_ok;
      if (rec_hit)
        param_err_r <= !rec_ok;
    end
  end

  // An abort stays latched until a new update starts running.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      fw_abort_r <= 1'b0;
    else
      fw_abort_r <= fw_abort_s | (fw_abort_r & ~fw_run_s);
  end

  assign fw_unavail = fw_run_s | fw_abort_r;
  assign fault_lamp_any   = param_err_r | fw_unavail;
  assign proc_load  = out_wr_valid && !fw_unavail;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      perr_q_r <= 1'b0;
      fwu_q_r  <= 1'b0;
      alarm_r  <= 1'b0;
      code_r   <= 8'h00;
    end
    else
    begin
      perr_q_r <= param_err_r;
      fwu_q_r  <= fw_unavail;
      alarm_r  <= (param_err_r & ~perr_q_r) | (fw_unavail & ~fwu_q_r);
      if (fw_unavail & ~fwu_q_r)
        code_r <= ERR_UNAVAIL;
      else if (param_err_r & ~perr_q_r)
        code_r <= ERR_PARAM;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      quality_r <= 8'h00;
      present_r <= 1'b0;
    end
    else
    begin
      quality_r <= fault_lamp_any ? 8'h00 : {4'h0, cfg_en_r};
      present_r <= cfg_qopt_r;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      flash_cnt_r <= '0;
      flash_r     <= 1'b0;
    end
    else if (flash_cnt_r == FLASH_LAST)
    begin
      flash_cnt_r <= '0;
      flash_r     <= ~flash_r;
    end
    else
      flash_cnt_r <= flash_cnt_r + 1'b1;
  end

  always_comb
  begin
    if (!bp_ok_s)
      lamp_mode = QOC_LAMP_DARK;
    else if (!assigned_r)
      lamp_mode = QOC_LAMP_UNSET;
    else if (fault_lamp_any)
      lamp_mode = QOC_LAMP_FAULT_LAMP;
    else
      lamp_mode = QOC_LAMP_OK;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      green_r  <= 1'b0;
      red_r    <= 1'b0;
      supply_r <= 1'b0;
    end
    else
    begin
      supply_r <= load_ok_s;
      unique case (lamp_mode)
        QOC_LAMP_DARK:
        begin
          green_r <= 1'b0;
          red_r   <= 1'b0;
        end
        QOC_LAMP_UNSET:
        begin
          green_r <= flash_r;
          red_r   <= 1'b0;
        end
        QOC_LAMP_OK:
        begin
          green_r <= 1'b1;
          red_r   <= 1'b0;
        end
        QOC_LAMP_FAULT_LAMP:
        begin
          green_r <= 1'b0;
          red_r   <= flash_r;
        end
      endcase
    end
  end

  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    qoc_chan_if ch_if ();
    assign ch_if.en    = cfg_en_r[i];
    assign ch_if.react = qoc_react_t'(cfg_react_r[2*i+1:2*i]);
    assign ch_if.stop  = stop_s;
    assign ch_if.load  = proc_load;
    assign ch_if.cmd   = output_image[i];
    assign chan_out[i]  = ch_if.out;
    assign chan_lamp[i] = ch_if.lamp;
    qoc_chan u_chan (
      .mclk (mclk),
      .nrst (nrst),
      .ch   (ch_if.chan)
    );
  end

  assign rec_wr_done         = done_r;
  assign rec_wr_err          = err_r;
  assign fault_lamp_green    = green_r;
  assign fault_lamp_red      = red_r;
  assign supply_lamp         = supply_r;
  assign load_status         = LOAD_STATUS;
  assign input_image_present = present_r;
  assign quality_info        = quality_r;
  assign fault_lamp_alarm          = alarm_r;
  assign fault_lamp_code           = code_r;
  assign fault_lamp_active         = fault_lamp_any;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_disabled_chan_off: assert property (
    ((~cfg_en_r & ~$past(cfg_en_r) & chan_out) == 4'h0))
    else $error("Disabled channel drives its output.");
  a_stop_turn_off: assert property (
    (stop_s && cfg_react_r[1:0] == 2'b00) |=> !chan_out[0])
    else $error("Channel 0 not off on stop.");
  a_stop_subst_one: assert property (
    (stop_s && cfg_en_r[0] && cfg_react_r[1:0] == 2'b10) |=> chan_out[0])
    else $error("Channel 0 not at substitute value on stop.");
  a_record_accept: assert property (
    rec_ok |=> assigned_r && !param_err_r && rec_wr_done)
    else $error("Good parameter record not taken.");
  a_bad_len_err: assert property (
    (rec_hit && rec_len != PARAM_REC_LEN) |=> param_err_r ##1 fault_lamp_code == ERR_PARAM)
    else $error("Bad record length not flagged with code 10.");
  a_quality_clear: assert property (
    $past(fault_lamp_any) |-> quality_info == 8'h00)
    else $error("Quality bits set during an error.");
  // Reset forces the quality byte to zero, so the edge right after release is exempt.
  a_quality_value: assert property (
    ($past(nrst) && !$past(fault_lamp_any)) |-> quality_info == {4'h0, $past(cfg_en_r)})
    else $error("Quality bits do not follow channel enables.");
  a_byte_absent: assert property (
    !$past(cfg_qopt_r) |-> !input_image_present)
    else $error("Input byte present without quality option.");
  a_chan_lamp: assert property (
    (chan_lamp & ~(chan_out & cfg_en_r)) == 4'h0)
    else $error("Channel lamp lit without enabled active output.");
  a_fw_code: assert property (
    $rose(fw_unavail) |=> fault_lamp_alarm && fault_lamp_code == ERR_UNAVAIL)
    else $error("Firmware update not reported with code 1F.");
  a_fw_frozen: assert property (
    (fw_unavail && !stop_s && $stable(cfg_en_r)) |=> $stable(chan_out))
    else $error("Process value taken during firmware update.");
  a_fault_lamp: assert property (
    (!bp_ok_s) |=> !fault_lamp_green && !fault_lamp_red)
    else $error("Fault lamp lit with bad backplane supply.");
  a_load_status: assert property (
    load_status == LOAD_STATUS)
    else $error("Load status does not read one.");

  c_record_ok: cover property (rec_ok ##1 rec_wr_done);
  c_stop_subst: cover property (stop_s && cfg_react_r[1:0] == 2'b10 ##1 chan_out[0]);
  c_alarm_param: cover property (fault_lamp_alarm && fault_lamp_code == ERR_PARAM);
  c_alarm_fw: cover property (fault_lamp_alarm && fault_lamp_code == ERR_UNAVAIL);
endmodule // qoc_top

/* src/qoc_pkg.sv */
// Shared constants and types for the quad output channel control block.
package qoc_pkg;
  localparam int unsigned NUM_CH         = 4;
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned FLASH_HALF_MS  = 250;
  localparam int unsigned FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam logic [15:0] PARAM_REC_IDX  = 16'h0080;
  localparam logic [7:0]  PARAM_REC_LEN  = 8'h03;
  localparam logic [7:0]  ERR_PARAM      = 8'h10;
  localparam logic [7:0]  ERR_UNAVAIL    = 8'h1f;
  localparam int unsigned EN_LSB         = 0;
  localparam int unsigned REACT_LSB      = 8;
  localparam int unsigned QOPT_BIT       = 16;
  localparam logic [3:0]  EN_RST         = 4'hf;
  localparam logic [7:0]  REACT_RST      = 8'h00;
  localparam logic        QOPT_RST       = 1'b0;
  localparam logic [7:0]  LOAD_STATUS    = 8'h01;

  typedef enum logic [1:0] {QOC_REACT_OFF, QOC_REACT_HOLD, QOC_REACT_SUBST, QOC_REACT_BAD}
    qoc_react_t;
  typedef enum logic [1:0] {QOC_LAMP_DARK, QOC_LAMP_UNSET, QOC_LAMP_OK, QOC_LAMP_FAULT_LAMP}
    qoc_lamp_t;
endpackage

/* src/qoc_chan_if.sv */
// Control and status bundle between the controller core and one output channel.
`timescale 1ns/100ps
interface qoc_chan_if
  import qoc_pkg::*;
  ();
  logic       en;
  qoc_react_t react;
  logic       stop;
  logic       load;
  logic       cmd;
  logic       out;
  logic       lamp;
  modport ctl  (output en, react, stop, load, cmd, input out, lamp);
  modport chan (input en, react, stop, load, cmd, output out, lamp);
endinterface

/* src/qoc_sync.sv */
// Two-stage synchroniser for a vector of asynchronous levels.
`timescale 1ns/100ps
module qoc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= '0;
      q_r    <= '0;
    end
    else
    begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;
endmodule // qoc_sync

/* src/qoc_chan.sv */
// One output channel: enable, stop reaction and commanded value.
`timescale 1ns/100ps
module qoc_chan
  import qoc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  qoc_chan_if.chan ch
);
  logic out_r;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      out_r <= 1'b0;
    else if (!ch.en)
      out_r <= 1'b0;
    else if (ch.stop)
    begin
      unique case (ch.react)
        QOC_REACT_OFF:   out_r <= 1'b0;
        QOC_REACT_HOLD:  out_r <= out_r;
        QOC_REACT_SUBST: out_r <= 1'b1;
        QOC_REACT_BAD:   out_r <= 1'b0;
      endcase
    end
    else if (ch.load)
      out_r <= ch.cmd;
  end

  assign ch.out  = out_r;
  assign ch.lamp = ch.en & out_r;
endmodule // qoc_chan

/* tb/qoc_ctrl_model.sv */
// Controller model that writes parameter records and output images.
`timescale 1ns/100ps
module qoc_ctrl_model (
  input  wire logic        mclk,
  output      logic        rec_wr_valid,
  output      logic [15:0] rec_index,
  output      logic [7:0]  rec_len,
  output      logic [23:0] rec_data,
  input  wire logic        rec_wr_done,
  input  wire logic        rec_wr_err,
  output      logic        out_wr_valid,
  output      logic [7:0]  output_image
);
  initial
  begin
    rec_wr_valid = 1'b0;
    rec_index    = 16'h0000;
    rec_len      = 8'h00;
    rec_data     = 24'h000000;
    out_wr_valid = 1'b0;
    output_image = 8'h00;
  end
  // Released lines are inverted so that a stale value is never taken for a live one.
  task automatic rec_write(input logic [15:0] idx, input logic [7:0] len,
                           input logic [23:0] data, output logic done, output logic err);
    @(negedge mclk);
    rec_wr_valid = 1'b1;
    rec_index    = idx;
    rec_len      = len;
    rec_data     = data;
    @(negedge mclk);
    done         = rec_wr_done;
    err          = rec_wr_err;
    rec_wr_valid = 1'b0;
    rec_index    = ~idx;
    rec_len      = ~len;
    rec_data     = ~data;
  endtask
  task automatic out_write(input logic [7:0] img);
    @(negedge mclk);
    out_wr_valid = 1'b1;
    output_image = img;
    @(negedge mclk);
    out_wr_valid = 1'b0;
    output_image = ~img;
  endtask
endmodule // qoc_ctrl_model

/* tb/quad_output_channel_control_tb_top.sv */
// Self-checking testbench for the quad output channel control block.
`timescale 1ns/100ps
module quad_output_channel_control_tb_top;
  import qoc_pkg::*;
  logic        mclk, nrst, stop_pin, bp_ok, load_pin, fw_run, fw_abort;
  logic        rec_wr_valid, rec_wr_done, rec_wr_err, out_wr_valid;
  logic [15:0] rec_index;
  logic [7:0]  rec_len, output_image, load_status, quality_info, fault_lamp_code;
  logic [23:0] rec_data;
  logic [3:0]  chan_out, chan_lamp;
  logic        fault_lamp_green, fault_lamp_red, supply_lamp;
  logic        input_image_present, fault_lamp_alarm, fault_lamp_active;
  int          mismatches, n_tests;
  logic [31:0] seed;

  qoc_ctrl_model i_ctl (.mclk(mclk), .rec_wr_valid(rec_wr_valid), .rec_index(rec_index),
    .rec_len(rec_len), .rec_data(rec_data), .rec_wr_done(rec_wr_done),
    .rec_wr_err(rec_wr_err), .out_wr_valid(out_wr_valid), .output_image(output_image));
  // A short flash period keeps lamp checks within a few dozen cycles.
  qoc_top #(.FLASH_CYC(4)) i_dut (.mclk(mclk), .nrst(nrst), .rec_wr_valid(rec_wr_valid),
    .rec_index(rec_index), .rec_len(rec_len), .rec_data(rec_data),
    .rec_wr_done(rec_wr_done), .rec_wr_err(rec_wr_err), .out_wr_valid(out_wr_valid),
    .output_image(output_image), .ctrl_stop_pin(stop_pin), .bp_supply_ok_pin(bp_ok),
    .load_supply_pin(load_pin), .fw_update_run_pin(fw_run),
    .fw_update_abort_pin(fw_abort), .chan_out(chan_out), .chan_lamp(chan_lamp),
    .fault_lamp_green(fault_lamp_green), .fault_lamp_red(fault_lamp_red),
    .supply_lamp(supply_lamp), .load_status(load_status),
    .input_image_present(input_image_present), .quality_info(quality_info),
    .fault_lamp_alarm(fault_lamp_alarm), .fault_lamp_code(fault_lamp_code), .fault_lamp_active(fault_lamp_active));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] cls(input int n);
    return (n == 0) ? 8'h00 : ((n == 20) ? 8'h02 : 8'h01);
  endfunction
  function automatic logic [3:0] exp_stop(input logic [7:0] re, input logic [3:0] prev);
    logic [3:0] r;
    for (int c = 0; c < 4; c++)
      r[c] = (re[2*c +: 2] == 2'h1) ? prev[c] : (re[2*c +: 2] == 2'h2);
    return r;
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic rec(input logic [15:0] idx, input logic [7:0] len, input logic [23:0] d,
                     input logic ok);
    logic done;
    logic err;
    i_ctl.rec_write(idx, len, d, done, err);
    chk("rec_wr_done", {7'h00, done}, {7'h00, ok});
    chk("rec_wr_err", {7'h00, err}, {7'h00, ~ok});
  endtask
  task automatic alarm_cnt(input logic [7:0] code);
    int n;
    n = 0;
    repeat (8)
    begin
      @(negedge mclk);
      n += fault_lamp_alarm;
    end
    chk("fault_lamp_alarm", n[7:0], 8'h01);
    chk("fault_lamp_code", fault_lamp_code, code);
  endtask
  // Lamp classes: 0 dark, 1 flashing, 2 steady.
  task automatic lamp(input logic [7:0] g, input logic [7:0] r);
    int ng;
    int nr;
    ng = 0;
    nr = 0;
    repeat (20)
    begin
      @(negedge mclk);
      ng += fault_lamp_green;
      nr += fault_lamp_red;
    end
    chk("fault_lamp_green", cls(ng), g);
    chk("fault_lamp_red", cls(nr), r);
  endtask

  initial
  begin
    #2000000;
    mismatches++;
    test_done();
  end

  initial
  begin
    logic [3:0] en;
    logic [3:0] last;
    logic [7:0] re;
    mismatches = 0;
    n_tests = 0;
    seed = 32'h17701dab;
    {stop_pin, load_pin, fw_run, fw_abort, nrst} = 5'h00;
    bp_ok = 1'b1;
    cyc(12);
    nrst = 1'b1;
    cyc(4);
    chk("load_status", load_status, 8'h01);
    chk("input_image_present", {7'h00, input_image_present}, 8'h00);
    lamp(8'h01, 8'h00);
    for (int i = 0; i < 12; i++)
    begin
      seed = lfsr(seed);
      en = seed[3:0];
      rec(16'h0080, 8'h03, {7'h00, seed[4], 12'h000, en}, 1'b1);
      cyc(1);
      chk("input_image_present", {7'h00, input_image_present}, {7'h00, seed[4]});
      if (seed[4])
        chk("quality_info", quality_info, {4'h0, en});
      i_ctl.out_write(seed[15:8]);
      chk("chan_out", {4'h0, chan_out}, {4'h0, seed[11:8] & en});
      chk("chan_lamp", {4'h0, chan_lamp}, {4'h0, seed[11:8] & en});
    end
    lamp(8'h02, 8'h00);
    load_pin = 1'b1;
    cyc(4);
    chk("supply_lamp", {7'h00, supply_lamp}, 8'h01);
    load_pin = 1'b0;
    cyc(4);
    chk("supply_lamp", {7'h00, supply_lamp}, 8'h00);
    chk("load_status", load_status, 8'h01);
    rec(16'h0080, 8'h03, 24'h01000f, 1'b1);
    rec(16'h0081, 8'h03, 24'h01000f, 1'b0);
    chk("fault_lamp_active", {7'h00, fault_lamp_active}, 8'h00);
    rec(16'h0080, 8'h02, 24'h01000f, 1'b0);
    alarm_cnt(8'h10);
    chk("quality_info", quality_info, 8'h00);
    lamp(8'h00, 8'h01);
    rec(16'h0080, 8'h03, 24'h01000f, 1'b1);
    cyc(2);
    chk("quality_info", quality_info, 8'h0f);
    rec(16'h0080, 8'h03, 24'h010c0f, 1'b0);
    alarm_cnt(8'h10);
    for (int k = 0; k < 3; k++)
    begin
      for (int c = 0; c < 4; c++)
        re[2*c +: 2] = 2'((c + k) % 3);
      rec(16'h0080, 8'h03, {8'h01, re, 8'h0f}, 1'b1);
      seed = lfsr(seed);
      i_ctl.out_write(seed[7:0]);
      last = exp_stop(re, seed[3:0]);
      stop_pin = 1'b1;
      cyc(4);
      chk("chan_out", {4'h0, chan_out}, {4'h0, last});
      stop_pin = 1'b0;
      cyc(4);
    end
    fw_abort = 1'b1;
    alarm_cnt(8'h1f);
    fw_abort = 1'b0;
    i_ctl.out_write({4'h0, ~last});
    chk("chan_out", {4'h0, chan_out}, {4'h0, last});
    chk("quality_info", quality_info, 8'h00);
    fw_run = 1'b1;
    cyc(4);
    fw_run = 1'b0;
    cyc(4);
    chk("fault_lamp_active", {7'h00, fault_lamp_active}, 8'h00);
    bp_ok = 1'b0;
    cyc(4);
    lamp(8'h00, 8'h00);
    test_done();
  end
endmodule // quad_output_channel_control_tb_top
